/* rtl/pps_pkg.sv */
`default_nettype none

package pps_pkg;

  // ----------------------------------------------------------------
  // Word layout on every port direction.
  // ----------------------------------------------------------------
  localparam int WORD_W     = 10;
  localparam int SYM_W      = 4;
  localparam int DATA_W     = 8;
  localparam int PAR_POS    = 9;
  localparam int CTRL_POS   = 8;
  localparam int SYM1_MSB   = 7;
  localparam int SYM1_LSB   = 4;
  localparam int SYM2_MSB   = 3;
  localparam int SYM2_LSB   = 0;
  localparam int NUM_PORTS  = 2;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  // An idle word of all-zero data with odd parity: parity bit set.
  localparam logic [9:0] IDLE_WORD = 10'h200;

  // ----------------------------------------------------------------
  // Request checker states.
  // ----------------------------------------------------------------
  typedef enum logic [0:0]
  {
    PPS_CHK_OK  = 1'b0,
    PPS_CHK_ERR = 1'b1
  } pps_chk_t;

endpackage : pps_pkg

`default_nettype wire

/* rtl/pps_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module pps_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,     // Core clock.
  input  wire logic             rst,     // Asynchronous reset, high.
  input  wire logic [WIDTH-1:0] in_data, // Word to store.
  input  wire logic             in_valid,// Word offered.
  output var  logic             in_ready,// Room available.
  output var  logic [WIDTH-1:0] out_data,// Oldest word.
  output var  logic             out_valid,// Oldest word present.
  input  wire logic             out_ready // Drain side takes word.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             in_ready_r;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Handshake terms.
  // ----------------------------------------------------------------
  // Empty comes from the occupancy count; ready is a flop so the port
  // that faces the core never carries a combinational path.
  assign in_ready  = in_ready_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage writes; no reset needed on the array.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Next occupancy, shared by the count and the registered ready.
  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = count_r + 1'b1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      in_ready_r <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  a_fifo_no_overfill : assert property (@(posedge clk) disable iff (rst)
    count_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");

  a_ready_tracks : assert property (@(posedge clk) disable iff (rst)
    in_ready_r == (count_r != (AW+1)'(DEPTH)))
    else $error("fifo ready does not match occupancy");

endmodule : pps_fifo

`default_nettype wire

/* rtl/pps_port.sv */
`timescale 1ns/10ps
`default_nettype none

module pps_port #(
  parameter int DEPTH = pps_pkg::FIFO_DEPTH
) (
  input  wire logic       CORE_CLK,            // Byte clock, 10 MHz.
  input  wire logic       RST,                 // Asynchronous reset, high.
  // Port one.
  output var  logic       PORT1_OUT_PARITY,    // Indicate odd parity.
  output var  logic       PORT1_OUT_CTRL_FLAG, // Indicate control flag.
  output var  logic [7:0] PORT1_OUT_SYMBOLS,   // Indicate symbol pair.
  input  wire logic       PORT1_IN_PARITY,     // Request odd parity.
  input  wire logic       PORT1_IN_CTRL_FLAG,  // Request control flag.
  input  wire logic [7:0] PORT1_IN_SYMBOLS,    // Request symbol pair.
  // Port two.
  output var  logic       PORT2_OUT_PARITY,    // Indicate odd parity.
  output var  logic       PORT2_OUT_CTRL_FLAG, // Indicate control flag.
  output var  logic [7:0] PORT2_OUT_SYMBOLS,   // Indicate symbol pair.
  input  wire logic       PORT2_IN_PARITY,     // Request odd parity.
  input  wire logic       PORT2_IN_CTRL_FLAG,  // Request control flag.
  input  wire logic [7:0] PORT2_IN_SYMBOLS,    // Request symbol pair.
  // Core side, indicate sources (one word per port).
  input  wire logic       P1_SRC_CTRL,         // Port one symbols are control.
  input  wire logic [3:0] P1_SRC_SYM1,         // Port one first symbol.
  input  wire logic [3:0] P1_SRC_SYM2,         // Port one second symbol.
  input  wire logic       P1_SRC_VALID,        // Port one word offered.
  output var  logic       P1_SRC_READY,        // Port one FIFO has room.
  input  wire logic       P2_SRC_CTRL,         // Port two symbols are control.
  input  wire logic [3:0] P2_SRC_SYM1,         // Port two first symbol.
  input  wire logic [3:0] P2_SRC_SYM2,         // Port two second symbol.
  input  wire logic       P2_SRC_VALID,        // Port two word offered.
  input  wire logic       PORT_HOLD,           // Stall both indicate paths.
  // Core side, received request words.
  output var  logic       P1_RX_CTRL,          // Port one received flag.
  output var  logic [7:0] P1_RX_SYMBOLS,       // Port one received pair.
  output var  logic       P1_PAR_ERR,          // Port one parity error pulse.
  output var  logic       P2_RX_CTRL,          // Port two received flag.
  output var  logic [7:0] P2_RX_SYMBOLS,       // Port two received pair.
  output var  logic       P2_PAR_ERR           // Port two parity error pulse.
);

  localparam int W = pps_pkg::WORD_W;

  // ----------------------------------------------------------------
  // Word helpers.
  // ----------------------------------------------------------------
  // ten-bit word
  // Builds the ten-bit word with parity so the ones count is odd.
  function automatic logic [9:0] pack_word(input logic ctrl, input logic [3:0] s1,
                                           input logic [3:0] s2);
    logic [8:0] body;
    body = {ctrl, s1, s2};
    return {~(^body), body};
  endfunction : pack_word

  // True when the ten bits hold an even count of ones.
  function automatic logic parity_bad(input logic [9:0] w);
    return ~(^w);
  endfunction : parity_bad

  logic [W-1:0] p1_fifo_out;
  logic [W-1:0] p2_fifo_out;
  logic         p1_fifo_valid;
  logic         p2_fifo_valid;
  logic         drain;

  // ----------------------------------------------------------------
  // Indicate path buffering.
  // ----------------------------------------------------------------
  // Both ports drain together so the two paths stay word-aligned;
  // the trade-off is that neither port can be stalled on its own.
  assign drain = !PORT_HOLD;

  pps_fifo #(
    .WIDTH (W),
    .DEPTH (DEPTH)
  ) u_fifo1 (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_data   (pack_word(P1_SRC_CTRL, P1_SRC_SYM1, P1_SRC_SYM2)),
    .in_valid  (P1_SRC_VALID),
    .in_ready  (P1_SRC_READY),
    .out_data  (p1_fifo_out),
    .out_valid (p1_fifo_valid),
    .out_ready (drain)
  );

  pps_fifo #(
    .WIDTH (W),
    .DEPTH (DEPTH)
  ) u_fifo2 (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_data   (pack_word(P2_SRC_CTRL, P2_SRC_SYM1, P2_SRC_SYM2)),
    .in_valid  (P2_SRC_VALID),
    .in_ready  (),
    .out_data  (p2_fifo_out),
    .out_valid (p2_fifo_valid),
    .out_ready (drain)
  );

  // ----------------------------------------------------------------
  // Indicate drivers.
  // ----------------------------------------------------------------
  // port one parity
  // one word per cycle
  // An empty FIFO sends the idle word so parity on the pins stays odd.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      {PORT1_OUT_PARITY, PORT1_OUT_CTRL_FLAG, PORT1_OUT_SYMBOLS} <= pps_pkg::IDLE_WORD;
    end
    else if (drain)
    begin
      {PORT1_OUT_PARITY, PORT1_OUT_CTRL_FLAG, PORT1_OUT_SYMBOLS} <=
        p1_fifo_valid ? p1_fifo_out : pps_pkg::IDLE_WORD;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      {PORT2_OUT_PARITY, PORT2_OUT_CTRL_FLAG, PORT2_OUT_SYMBOLS} <= pps_pkg::IDLE_WORD;
    end
    else if (drain)
    begin
      {PORT2_OUT_PARITY, PORT2_OUT_CTRL_FLAG, PORT2_OUT_SYMBOLS} <=
        p2_fifo_valid ? p2_fifo_out : pps_pkg::IDLE_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Request sampling.
  // ----------------------------------------------------------------
  // Pins come from another chip, so two flops before any logic.
  logic [W-1:0] p1_meta_r;
  logic [W-1:0] p1_sync_r;
  logic [W-1:0] p2_meta_r;
  logic [W-1:0] p2_sync_r;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      p1_meta_r <= pps_pkg::IDLE_WORD;
      p1_sync_r <= pps_pkg::IDLE_WORD;
      p2_meta_r <= pps_pkg::IDLE_WORD;
      p2_sync_r <= pps_pkg::IDLE_WORD;
    end
    else
    begin
      p1_meta_r <= {PORT1_IN_PARITY, PORT1_IN_CTRL_FLAG, PORT1_IN_SYMBOLS};
      p1_sync_r <= p1_meta_r;
      p2_meta_r <= {PORT2_IN_PARITY, PORT2_IN_CTRL_FLAG, PORT2_IN_SYMBOLS};
      p2_sync_r <= p2_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Request checking and delivery.
  // ----------------------------------------------------------------
  // parity check
  // relies on odd request parity
  // Bad words are still delivered; only the error pulse marks them.
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      P1_RX_CTRL    <= 1'b0;
      P1_RX_SYMBOLS <= 8'h00;
      P1_PAR_ERR    <= 1'b0;
      P2_RX_CTRL    <= 1'b0;
      P2_RX_SYMBOLS <= 8'h00;
      P2_PAR_ERR    <= 1'b0;
    end
    else
    begin
      P1_RX_CTRL    <= p1_sync_r[pps_pkg::CTRL_POS];
      P1_RX_SYMBOLS <= p1_sync_r[pps_pkg::SYM1_MSB:pps_pkg::SYM2_LSB];
      P1_PAR_ERR    <= parity_bad(p1_sync_r);
      P2_RX_CTRL    <= p2_sync_r[pps_pkg::CTRL_POS];
      P2_RX_SYMBOLS <= p2_sync_r[pps_pkg::SYM1_MSB:pps_pkg::SYM2_LSB];
      P2_PAR_ERR    <= parity_bad(p2_sync_r);
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  sequence s_bad_req1;
    !(^{PORT1_IN_PARITY, PORT1_IN_CTRL_FLAG, PORT1_IN_SYMBOLS});
  endsequence

  // Request steps: a word stands on the pins, three edges later it is out.
  sequence s_bad_req2;
    !(^{PORT2_IN_PARITY, PORT2_IN_CTRL_FLAG, PORT2_IN_SYMBOLS});
  endsequence

  sequence s_good_req1;
    ^{PORT1_IN_PARITY, PORT1_IN_CTRL_FLAG, PORT1_IN_SYMBOLS};
  endsequence

  // Indicate step: port two hands its oldest word to the pins.
  sequence s_pop2;
    drain && p2_fifo_valid;
  endsequence

  a_port1_odd_out : assert property (@(posedge CORE_CLK) disable iff (RST)
    ^{PORT1_OUT_PARITY, PORT1_OUT_CTRL_FLAG, PORT1_OUT_SYMBOLS})
    else $error("port one indicate parity not odd");

  a_port2_odd_out : assert property (@(posedge CORE_CLK) disable iff (RST)
    ^{PORT2_OUT_PARITY, PORT2_OUT_CTRL_FLAG, PORT2_OUT_SYMBOLS})
    else $error("port two indicate parity not odd");

  a_ctrl_flag_path : assert property (@(posedge CORE_CLK) disable iff (RST)
    (drain && p1_fifo_valid) |=> PORT1_OUT_CTRL_FLAG == $past(p1_fifo_out[pps_pkg::CTRL_POS]))
    else $error("control flag not carried");

  a_first_symbol : assert property (@(posedge CORE_CLK) disable iff (RST)
    (drain && p1_fifo_valid) |=> PORT1_OUT_SYMBOLS[7:4] == $past(p1_fifo_out[7:4]))
    else $error("first symbol misplaced");

  a_second_symbol : assert property (@(posedge CORE_CLK) disable iff (RST)
    (drain && p2_fifo_valid) |=> PORT2_OUT_SYMBOLS[3:0] == $past(p2_fifo_out[3:0]))
    else $error("second symbol misplaced");

  a_par_err_flag : assert property (@(posedge CORE_CLK) disable iff (RST)
    s_bad_req1 ##3 1'b1 |-> P1_PAR_ERR)
    else $error("bad request parity not flagged");

  a_par_ok_quiet : assert property (@(posedge CORE_CLK) disable iff (RST)
    (^{PORT2_IN_PARITY, PORT2_IN_CTRL_FLAG, PORT2_IN_SYMBOLS}) |-> ##3 !P2_PAR_ERR)
    else $error("good request flagged");

  a_rx_latency : assert property (@(posedge CORE_CLK) disable iff (RST)
    1'b1 |-> ##3 P1_RX_SYMBOLS == $past(PORT1_IN_SYMBOLS, 3))
    else $error("request word latency wrong");

  a_hold_freezes : assert property (@(posedge CORE_CLK) disable iff (RST)
    PORT_HOLD |=> $stable(PORT2_OUT_SYMBOLS) && $stable(PORT1_OUT_SYMBOLS))
    else $error("indicate changed while held");

  a_port2_ctrl_flag : assert property (@(posedge CORE_CLK) disable iff (RST)
    s_pop2 |=> PORT2_OUT_CTRL_FLAG == $past(p2_fifo_out[pps_pkg::CTRL_POS]))
    else $error("port two control flag not carried");

  a_port2_first_sym : assert property (@(posedge CORE_CLK) disable iff (RST)
    s_pop2 |=> PORT2_OUT_SYMBOLS[7:4] == $past(p2_fifo_out[7:4]))
    else $error("port two first symbol misplaced");

  a_port1_second_sym : assert property (@(posedge CORE_CLK) disable iff (RST)
    (drain && p1_fifo_valid) |=> PORT1_OUT_SYMBOLS[3:0] == $past(p1_fifo_out[3:0]))
    else $error("port one second symbol misplaced");

  a_idle_when_empty : assert property (@(posedge CORE_CLK) disable iff (RST)
    (drain && !p1_fifo_valid) |=>
      {PORT1_OUT_PARITY, PORT1_OUT_CTRL_FLAG, PORT1_OUT_SYMBOLS} == pps_pkg::IDLE_WORD)
    else $error("idle word not sent while empty");

  a_port2_par_err : assert property (@(posedge CORE_CLK) disable iff (RST)
    s_bad_req2 ##3 1'b1 |-> P2_PAR_ERR)
    else $error("bad port two request parity not flagged");

  a_port1_par_quiet : assert property (@(posedge CORE_CLK) disable iff (RST)
    s_good_req1 |-> ##3 !P1_PAR_ERR)
    else $error("good port one request flagged");

  a_rx2_latency : assert property (@(posedge CORE_CLK) disable iff (RST)
    1'b1 |-> ##3 P2_RX_SYMBOLS == $past(PORT2_IN_SYMBOLS, 3))
    else $error("port two request word latency wrong");

  a_rx_ctrl_latency : assert property (@(posedge CORE_CLK) disable iff (RST)
    1'b1 |-> ##3 P1_RX_CTRL == $past(PORT1_IN_CTRL_FLAG, 3))
    else $error("port one control flag latency wrong");

  a_hold_words : assert property (@(posedge CORE_CLK) disable iff (RST)
    PORT_HOLD |=> $stable({PORT1_OUT_PARITY, PORT1_OUT_CTRL_FLAG})
      && $stable({PORT2_OUT_PARITY, PORT2_OUT_CTRL_FLAG}))
    else $error("indicate flags changed while held");

endmodule : pps_port

`default_nettype wire

/* test/pps_far_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Far party that drives one request path.
// ----------------------------------------------------------------
module pps_far_model (
  input  wire logic       clk,       // Byte clock.
  input  wire logic       ctrl,      // Symbols are control.
  input  wire logic [3:0] sym1,      // First symbol.
  input  wire logic [3:0] sym2,      // Second symbol.
  input  wire logic       corrupt,   // Send even parity on purpose.
  output var  logic       parity,    // Request parity pin.
  output var  logic       ctrl_flag, // Request control pin.
  output var  logic [7:0] symbols    // Request symbol pins.
);
  // flag and order
  // Words launch just after the edge, so the pins never move at sampling.
  always @(posedge clk)
  begin
    ctrl_flag <= #1 ctrl;
    symbols   <= #1 {sym1, sym2};
    parity    <= #1 (~^{ctrl, sym1, sym2}) ^ corrupt;
  end
endmodule : pps_far_model

`default_nettype wire

/* test/pps_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check_val(10'(g), 10'(e))

module pps_port_tb;
  // ----------------------------------------------------------------
  // Bench signals.
  // ----------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       p1_op, p1_oc, p2_op, p2_oc, p1_ready, p1_rc, p2_rc, p1_pe, p2_pe;
  logic       p1_ip, p1_ic, p2_ip, p2_ic;
  logic [7:0] p1_os, p2_os, p1_rs, p2_rs, p1_is, p2_is;
  logic       s1_c = 1'b0, s1_v = 1'b0, s2_c = 1'b0, s2_v = 1'b0, hold = 1'b0;
  logic [3:0] s1_a = 4'h0, s1_b = 4'h0, s2_a = 4'h0, s2_b = 4'h0;
  logic       f1_c = 1'b0, f2_c = 1'b0, f1_bad = 1'b0, f2_bad = 1'b0;
  logic [3:0] f1_a = 4'h0, f1_b = 4'h0, f2_a = 4'h0, f2_b = 4'h0;
  int         error_cnt = 0;
  int         checks = 0;

  // The clock runs at 10 MHz.
  always #50 clk = ~clk;

  pps_port u_pps_port (
    .CORE_CLK(clk), .RST(rst),
    .PORT1_OUT_PARITY(p1_op), .PORT1_OUT_CTRL_FLAG(p1_oc), .PORT1_OUT_SYMBOLS(p1_os),
    .PORT1_IN_PARITY(p1_ip), .PORT1_IN_CTRL_FLAG(p1_ic), .PORT1_IN_SYMBOLS(p1_is),
    .PORT2_OUT_PARITY(p2_op), .PORT2_OUT_CTRL_FLAG(p2_oc), .PORT2_OUT_SYMBOLS(p2_os),
    .PORT2_IN_PARITY(p2_ip), .PORT2_IN_CTRL_FLAG(p2_ic), .PORT2_IN_SYMBOLS(p2_is),
    .P1_SRC_CTRL(s1_c), .P1_SRC_SYM1(s1_a), .P1_SRC_SYM2(s1_b), .P1_SRC_VALID(s1_v),
    .P1_SRC_READY(p1_ready),
    .P2_SRC_CTRL(s2_c), .P2_SRC_SYM1(s2_a), .P2_SRC_SYM2(s2_b), .P2_SRC_VALID(s2_v),
    .PORT_HOLD(hold),
    .P1_RX_CTRL(p1_rc), .P1_RX_SYMBOLS(p1_rs), .P1_PAR_ERR(p1_pe),
    .P2_RX_CTRL(p2_rc), .P2_RX_SYMBOLS(p2_rs), .P2_PAR_ERR(p2_pe)
  );

  pps_far_model u_pps_far_model_1 (
    .clk(clk), .ctrl(f1_c), .sym1(f1_a), .sym2(f1_b), .corrupt(f1_bad),
    .parity(p1_ip), .ctrl_flag(p1_ic), .symbols(p1_is)
  );

  pps_far_model u_pps_far_model_2 (
    .clk(clk), .ctrl(f2_c), .sym1(f2_a), .sym2(f2_b), .corrupt(f2_bad),
    .parity(p2_ip), .ctrl_flag(p2_ic), .symbols(p2_is)
  );

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  // Expected word: odd parity over all ten bits, first symbol on top.
  function automatic logic [9:0] enc(input logic c, input logic [3:0] a, input logic [3:0] b);
    return {~^{c, a, b}, c, a, b};
  endfunction : enc

  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // Inputs always move 1 ns after the rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic complete_run();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic reset_values();
    `CHK({p1_op, p1_oc, p1_os}, 10'h200);
    `CHK({p2_op, p2_oc, p2_os}, 10'h200);
    `CHK({p1_pe, p2_pe}, 2'h0);
  endtask : reset_values

  // Both ports carry the same word with the symbols swapped on port two.
  task automatic indicate_words();
    logic [8:0] tbl [4] = '{9'h15d, 9'h081, 9'h1ff, 9'h007};
    int n;
    foreach (tbl[i])
    begin
      {s1_c, s1_a, s1_b} = tbl[i];
      {s2_c, s2_a, s2_b} = {tbl[i][8], tbl[i][3:0], tbl[i][7:4]};
      s1_v = 1'b1;
      s2_v = 1'b1;
      tick();
      s1_v = 1'b0;
      s2_v = 1'b0;
      n = 0;
      while ({p1_op, p1_oc, p1_os} === 10'h200 && n < 6)
      begin
        tick();
        n++;
      end
      `CHK(n, 1);
      `CHK({p1_op, p1_oc, p1_os}, enc(tbl[i][8], tbl[i][7:4], tbl[i][3:0]));
      `CHK({p2_op, p2_oc, p2_os}, enc(tbl[i][8], tbl[i][3:0], tbl[i][7:4]));
      tick();
      `CHK({p1_op, p1_oc, p1_os}, 10'h200);
    end
  endtask : indicate_words

  // Single request words, good and bad parity, crossing on both ports.
  task automatic request_words();
    logic [9:0] tbl [4] = '{10'h13a, 10'h2c5, 10'h0f0, 10'h3e1};
    int n;
    foreach (tbl[i])
    begin
      {f1_bad, f1_c, f1_a, f1_b} = tbl[i];
      {f2_bad, f2_c, f2_a, f2_b} = {~tbl[i][9], tbl[i][8], ~tbl[i][7:0]};
      tick();
      {f1_bad, f1_c, f1_a, f1_b} = 10'h000;
      {f2_bad, f2_c, f2_a, f2_b} = 10'h000;
      n = 0;
      while ({p1_rc, p1_rs} !== tbl[i][8:0] && n < 8)
      begin
        tick();
        n++;
      end
      `CHK(n, 3);
      `CHK({p1_pe, p1_rc, p1_rs}, tbl[i]);
      `CHK({p2_pe, p2_rc, p2_rs}, {~tbl[i][9], tbl[i][8], ~tbl[i][7:0]});
      tick();
      `CHK({p1_pe, p2_pe}, 2'h0);
    end
  endtask : request_words

  // Fill port one while held, then drain and check order and pacing.
  task automatic fifo_fill_drain();
    int acc = 0;
    int n = 0;
    hold = 1'b1;
    s1_c = 1'b0;
    while (p1_ready === 1'b1 && acc < 12)
    begin
      {s1_a, s1_b} = {4'(acc + 1), 4'(acc)};
      s1_v = 1'b1;
      tick();
      acc++;
    end
    // A word offered while full must be refused and never come out.
    {s1_a, s1_b} = 8'hee;
    tick();
    s1_v = 1'b0;
    `CHK(acc, 8);
    `CHK(p1_ready, 1'b0);
    hold = 1'b0;
    while ({p1_op, p1_oc, p1_os} === 10'h200 && n < 6)
    begin
      tick();
      n++;
    end
    `CHK(n, 1);
    for (int i = 0; i < 8; i++)
    begin
      `CHK({p1_op, p1_oc, p1_os}, enc(1'b0, 4'(i + 1), 4'(i)));
      tick();
    end
    `CHK({p1_op, p1_oc, p1_os}, 10'h200);
  endtask : fifo_fill_drain

  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    tick();
    reset_values();
    indicate_words();
    request_words();
    fifo_fill_drain();
    complete_run();
  end

  // The scenarios need well under 200 cycles.
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule : pps_port_tb

`default_nettype wire
